// >>> mdss_sample_sync.sv
/*
 multi-device sample sync: timebase share, sync pulse, start trigger.
 assumes one ref_clk domain; trigger lines, star line and timebase arrive
 from peers asynchronously and are sampled here with two flops.
*/
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mdss_map.svh"

module mdss_sample_sync
	import mdss_pkg::*;
#(
	parameter int LINES = 10,
	parameter int SETTLE_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic local_timebase,
	input wire logic star_in,
	output logic star_out,
	output logic star_oe,
	input wire logic [LINES-1:0] bus_in,
	output logic [LINES-1:0] bus_out,
	output logic [LINES-1:0] bus_oe,
	output logic conv_reset,
	output logic conv_ready,
	output logic acq_run,
	output logic sample_strobe
);

	localparam int PULSE_CYC = (`MDSS_PULSE_LEN_NS + `MDSS_CLK_PERIOD_NS - 1) / `MDSS_CLK_PERIOD_NS;

	logic [7:0] ctrl_reg;
	logic [11:0] route_reg;
	logic [15:0] delay_reg;
	logic [3:0] rate_reg;
	logic [SETTLE_W-1:0] settle_reg;
	logic [15:0] latency_reg;
	logic [15:0] latency_next;
	mdss_state_type state_reg;

	logic [LINES-1:0] bus_s1_reg, bus_s2_reg;
	logic star_s1_reg, star_s2_reg;
	logic ltb_s1_reg, ltb_s2_reg;
	logic tb_prev_reg, sync_prev_reg, start_prev_reg;

	wire logic is_master = ctrl_reg[`MDSS_CTRL_MASTER];
	wire logic chassis = ctrl_reg[`MDSS_CTRL_CHASSIS];
	wire logic eff_master = is_master & ~ctrl_reg[`MDSS_CTRL_EXPRESS];
	wire logic [3:0] tb_line = route_reg[`MDSS_ROUTE_TB_LSB +: 4];
	wire logic [3:0] sync_line = route_reg[`MDSS_ROUTE_SYNC_LSB +: 4];
	wire logic [3:0] start_line = route_reg[`MDSS_ROUTE_START_LSB +: 4];

	wire logic tb_shared = chassis ? star_s2_reg :
		(eff_master ? ltb_s2_reg : bus_s2_reg[tb_line]);
	wire logic tb_rise = tb_shared & ~tb_prev_reg;
	wire logic sync_lvl = bus_s2_reg[sync_line];
	wire logic start_lvl = bus_s2_reg[start_line];

	logic sync_seen, start_seen;
	assign sync_seen = tb_rise & sync_lvl & ~sync_prev_reg;
	assign start_seen = tb_rise & start_lvl & ~start_prev_reg;

	// inputs from peers are asynchronous: two flops before any use
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_s1_reg <= '0;
			bus_s2_reg <= '0;
			star_s1_reg <= 1'b0;
			star_s2_reg <= 1'b0;
			ltb_s1_reg <= 1'b0;
			ltb_s2_reg <= 1'b0;
		end else begin
			bus_s1_reg <= bus_in;
			bus_s2_reg <= bus_s1_reg;
			star_s1_reg <= star_in;
			star_s2_reg <= star_s1_reg;
			ltb_s1_reg <= local_timebase;
			ltb_s2_reg <= ltb_s1_reg;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tb_prev_reg <= 1'b0;
			sync_prev_reg <= 1'b0;
			start_prev_reg <= 1'b0;
		end else begin
			tb_prev_reg <= tb_shared;
			if (tb_rise) begin
				sync_prev_reg <= sync_lvl;
				start_prev_reg <= start_lvl;
			end
		end
	end

	// register writes; go bit self-clears
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= 8'h00;
			route_reg <= `MDSS_ROUTE_RESET;
			delay_reg <= `MDSS_DELAY_RESET;
			rate_reg <= `MDSS_RATE_RESET;
			settle_reg <= SETTLE_W'(`MDSS_SETTLE_SAMPLES_DEFAULT);
		end else begin
			ctrl_reg[`MDSS_CTRL_GO] <= 1'b0;
			if (reg_wr) begin
				unique case (reg_addr)
					`MDSS_ADDR_CTRL: ctrl_reg <= reg_wdata[7:0];
					`MDSS_ADDR_ROUTE: begin
						route_reg[7:0] <= reg_wdata[7:0];
						route_reg[11:8] <= (reg_wdata[11:8] > `MDSS_START_LINE_MAX) ?
							`MDSS_START_LINE_MAX : reg_wdata[11:8];
					end
					`MDSS_ADDR_DELAY: delay_reg <= reg_wdata;
					`MDSS_ADDR_RATE: rate_reg <= reg_wdata[3:0];
					`MDSS_ADDR_SETTLE: settle_reg <= reg_wdata[SETTLE_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// sample-clock divider off the shared timebase
	logic [15:0] div_reg;
	logic [3:0] eff_rate;
	logic samp_en;
	assign eff_rate = ctrl_reg[`MDSS_CTRL_ALIAS_REJ] ?
		((rate_reg > `MDSS_ALIAS_OVERSAMPLE_LOG2) ? rate_reg - `MDSS_ALIAS_OVERSAMPLE_LOG2 : 4'h0) :
		rate_reg;
	assign samp_en = tb_rise & ((div_reg & ((16'h0001 << eff_rate) - 16'h0001)) == 16'h0000);

	// decimation back to requested rate
	// low rates gain less than four, so decimate only by what was gained
	logic [1:0] dec_reg;
	logic [3:0] dec_log2;
	assign dec_log2 = rate_reg - eff_rate;
	wire logic [1:0] dec_mask = (dec_log2 == 4'h2) ? 2'h3 : ((dec_log2 == 4'h1) ? 2'h1 : 2'h0);
	wire logic out_en = samp_en & ((dec_reg & dec_mask) == 2'h0);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_reg <= 16'h0000;
			dec_reg <= 2'h0;
		end else if (sync_seen) begin
			div_reg <= 16'h0000;
			dec_reg <= 2'h0;
		end else if (tb_rise) begin
			div_reg <= div_reg + 16'h0001;
			if (samp_en)
				dec_reg <= dec_reg + 2'h1;
		end
	end

	// sequence state machine
	logic [SETTLE_W-1:0] settle_cnt_reg;
	logic [15:0] wait_cnt_reg;
	logic [7:0] pulse_cnt_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= MDSS_IDLE;
			settle_cnt_reg <= '0;
			wait_cnt_reg <= 16'h0000;
		end else begin
			unique case (state_reg)
				MDSS_IDLE: begin
					if (sync_seen) begin
						state_reg <= MDSS_SETTLE;
						settle_cnt_reg <= settle_reg;
					end
				end
				MDSS_SYNC: state_reg <= MDSS_SETTLE;
				MDSS_SETTLE: begin
					if (sync_seen)
						settle_cnt_reg <= settle_reg;
					else if (settle_cnt_reg == '0)
						state_reg <= MDSS_ARMED;
					else if (samp_en)
						settle_cnt_reg <= settle_cnt_reg - 1'b1;
				end
				MDSS_ARMED: begin
					// a late sync resettles; exporter starts after delay
					if (sync_seen) begin
						state_reg <= MDSS_SETTLE;
						settle_cnt_reg <= settle_reg;
					end else if (ctrl_reg[`MDSS_CTRL_GO] && ctrl_reg[`MDSS_CTRL_START_EXP]) begin
						state_reg <= MDSS_WAIT;
						wait_cnt_reg <= delay_reg;
					end else if (start_seen && ctrl_reg[`MDSS_CTRL_ARM]) begin
						state_reg <= MDSS_RUN;
					end
				end
				MDSS_WAIT: begin
					// delay before the exported start; a start seen runs at once; a sync resettles
					if (sync_seen) begin
						state_reg <= MDSS_SETTLE;
						settle_cnt_reg <= settle_reg;
					end else if (start_seen)
						state_reg <= MDSS_RUN;
					else if (tb_rise && wait_cnt_reg != 16'h0000)
						wait_cnt_reg <= wait_cnt_reg - 16'h0001;
				end
				MDSS_RUN: begin
					if (!ctrl_reg[`MDSS_CTRL_ARM])
						state_reg <= MDSS_IDLE;
					else if (sync_seen) begin
						state_reg <= MDSS_SETTLE;
						settle_cnt_reg <= settle_reg;
					end
				end
				default: state_reg <= MDSS_IDLE;
			endcase
		end
	end

	// pulse generators for exported sync and start
	logic sync_drive_reg, start_drive_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_drive_reg <= 1'b0;
			start_drive_reg <= 1'b0;
			pulse_cnt_reg <= 8'h00;
		end else if (pulse_cnt_reg != 8'h00) begin
			pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
			if (pulse_cnt_reg == 8'h01) begin
				sync_drive_reg <= 1'b0;
				start_drive_reg <= 1'b0;
			end
		end else if (ctrl_reg[`MDSS_CTRL_GO] && ctrl_reg[`MDSS_CTRL_SYNC_EXP] && eff_master
			&& state_reg == MDSS_IDLE) begin
			sync_drive_reg <= 1'b1;
			pulse_cnt_reg <= 8'(PULSE_CYC) + 8'h20;
		end else if (state_reg == MDSS_WAIT && wait_cnt_reg == 16'h0000 && !start_drive_reg) begin
			start_drive_reg <= 1'b1;
			pulse_cnt_reg <= 8'(PULSE_CYC) + 8'h20;
		end
	end

	// sync latency in timebase edges, measured from the sync seen on sync_line to settle end
	always_comb begin
		latency_next = latency_reg;
		if (sync_seen)
			latency_next = 16'h0000;
		else if (state_reg == MDSS_SETTLE && tb_rise && latency_reg != 16'hffff)
			latency_next = latency_reg + 16'h0001;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			latency_reg <= 16'h0000;
		else
			latency_reg <= latency_next;
	end

	// pin drivers, all registered
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			star_out <= 1'b0;
			star_oe <= 1'b0;
			bus_out <= '0;
			bus_oe <= '0;
		end else begin
			star_oe <= eff_master & chassis;
			star_out <= ltb_s2_reg;
			for (int i = 0; i < LINES; i++) begin
				bus_oe[i] <= (eff_master & ~chassis & (tb_line == 4'(i))) |
					(sync_drive_reg & (sync_line == 4'(i))) |
					(start_drive_reg & (start_line == 4'(i)));
				bus_out[i] <= (eff_master & ~chassis & (tb_line == 4'(i))) ? ltb_s2_reg :
					((sync_drive_reg & (sync_line == 4'(i))) |
					(start_drive_reg & (start_line == 4'(i))));
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conv_reset <= 1'b1;
			conv_ready <= 1'b0;
			acq_run <= 1'b0;
			sample_strobe <= 1'b0;
		end else begin
			conv_reset <= (state_reg == MDSS_IDLE) | (state_reg == MDSS_SETTLE) | sync_seen;
			// not ready nor running in the cycle a sync resets the converters
			conv_ready <= ((state_reg == MDSS_ARMED) | (state_reg == MDSS_WAIT) |
				(state_reg == MDSS_RUN)) & ~sync_seen;
			acq_run <= (state_reg == MDSS_RUN) & ~sync_seen;
			sample_strobe <= out_en & (state_reg == MDSS_RUN) & ~sync_seen;
		end
	end

	// read port: data one cycle after strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			unique case (reg_addr)
				`MDSS_ADDR_CTRL: reg_rdata <= {8'h00, ctrl_reg};
				`MDSS_ADDR_ROUTE: reg_rdata <= {4'h0, route_reg};
				`MDSS_ADDR_DELAY: reg_rdata <= delay_reg;
				`MDSS_ADDR_RATE: reg_rdata <= {12'h000, rate_reg};
				`MDSS_ADDR_STATUS: reg_rdata <= {13'h0000, state_reg};
				`MDSS_ADDR_LATENCY: reg_rdata <= latency_reg;
				`MDSS_ADDR_SETTLE: reg_rdata <= 16'(settle_reg);
				default: reg_rdata <= 16'h0000;
			endcase
		end else
			reg_rdata <= 16'h0000;
	end

endmodule
`default_nettype wire

// >>> mdss_map.svh
/*
 register map and timing constants for the multi-device sample sync block.
 assumes inclusion by mdss_pkg.sv and the design file by bare name.
*/
`ifndef MDSS_MAP_SVH
`define MDSS_MAP_SVH

`define MDSS_ADDR_CTRL 4'h0
`define MDSS_ADDR_ROUTE 4'h1
`define MDSS_ADDR_DELAY 4'h2
`define MDSS_ADDR_RATE 4'h3
`define MDSS_ADDR_STATUS 4'h4
`define MDSS_ADDR_LATENCY 4'h5
`define MDSS_ADDR_SETTLE 4'h6

`define MDSS_CTRL_MASTER 0
`define MDSS_CTRL_CHASSIS 1
`define MDSS_CTRL_EXPRESS 2
`define MDSS_CTRL_SYNC_EXP 3
`define MDSS_CTRL_START_EXP 4
`define MDSS_CTRL_ARM 5
`define MDSS_CTRL_GO 6
`define MDSS_CTRL_ALIAS_REJ 7

`define MDSS_ROUTE_TB_LSB 0
`define MDSS_ROUTE_SYNC_LSB 4
`define MDSS_ROUTE_START_LSB 8
`define MDSS_ROUTE_RESET 12'h098

`define MDSS_TB_LINE_DEFAULT 4'h8
`define MDSS_SYNC_LINE_DEFAULT 4'h9
`define MDSS_START_LINE_MAX 4'h6

`define MDSS_SETTLE_SAMPLES_DEFAULT 16'h0100
`define MDSS_DELAY_RESET 16'h0010
`define MDSS_RATE_RESET 4'h0
`define MDSS_ALIAS_OVERSAMPLE_LOG2 4'h2
`define MDSS_PULSE_LEN_NS 100
`define MDSS_CLK_PERIOD_NS 10

`endif

// >>> mdss_pkg.sv
/*
 types for the multi-device sample sync block.
 assumes mdss_map.svh is on the include path.
*/
`default_nettype none
`include "mdss_map.svh"

package mdss_pkg;
	typedef enum logic [2:0] {
		MDSS_IDLE = 3'b000,
		MDSS_SYNC = 3'b001,
		MDSS_SETTLE = 3'b010,
		MDSS_ARMED = 3'b011,
		MDSS_WAIT = 3'b100,
		MDSS_RUN = 3'b101
	} mdss_state_type;
endpackage
`default_nettype wire

// >>> mdss_assertions.sv
/*
 checker for the sample sync block, bound to its ports.
 assumes one ref_clk domain and the async high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module mdss_chk #(
	parameter int LINES = 10
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [LINES-1:0] bus_oe,
	input wire logic conv_reset,
	input wire logic conv_ready,
	input wire logic acq_run,
	input wire logic sample_strobe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_reset_rise; $rose(conv_reset); endsequence
	sequence s_reset_hold; conv_reset [*8]; endsequence
	sequence s_sync_rise; $rose(bus_oe[9]); endsequence
	sequence s_sync_hold; bus_oe[9] [*8]; endsequence
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	property p_strobe_run; sample_strobe |-> acq_run; endproperty
	property p_strobe_pulse; sample_strobe |=> !sample_strobe; endproperty
	property p_ready_rst; conv_ready |-> !conv_reset; endproperty
	property p_run_ready; $rose(acq_run) |-> conv_ready; endproperty
	property p_sync_len; s_sync_rise |-> s_sync_hold; endproperty
	property p_reset_hold; s_reset_rise |-> s_reset_hold; endproperty
	property p_ready_after; $rose(conv_ready) |-> $past(conv_reset); endproperty
	property p_run_rst; acq_run |-> !conv_reset; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	a_strobe_run: assert property (p_strobe_run) else $error("strobe while idle");
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
	a_ready_rst: assert property (p_ready_rst) else $error("ready in reset");
	a_run_ready: assert property (p_run_ready) else $error("run before ready");
	a_sync_len: assert property (p_sync_len) else $error("sync pulse short");
	a_reset_hold: assert property (p_reset_hold) else $error("reset too short");
	a_ready_after: assert property (p_ready_after) else $error("ready without reset");
	a_run_rst: assert property (p_run_rst) else $error("running while converters reset");
endmodule
bind mdss_sample_sync mdss_chk #(.LINES(LINES)) i_chk (.ref_clk(ref_clk), .rst(rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_oe(bus_oe), .conv_reset(conv_reset),
	.conv_ready(conv_ready), .acq_run(acq_run), .sample_strobe(sample_strobe));
`default_nettype wire

// >>> mdss_peer.sv
/*
 peer device: free-running 160 ns timebase and trigger pulses.
 assumes the bench resolves lines; released lines read low.
*/
`timescale 1ns/1ps
`default_nettype none
module mdss_peer (
	input wire logic ref_clk,
	output logic timebase,
	output logic [9:0] peer_out,
	output logic [9:0] peer_oe
);
	logic tb_drive = 1'b1;
	logic [9:0] trig = 10'h000;
	// low slot, committed first, same alias setting, never faster
	assign peer_out = trig | {1'b0, timebase, 8'h00};
	assign peer_oe = trig | {1'b0, tb_drive, 8'h00};
	initial begin
		timebase = 1'b0;
		#3;
		forever #80 timebase = ~timebase;
	end
	// line 8 handed to the device under test as master
	task release_tb;
		tb_drive <= 1'b0;
	endtask
	task pulse(input int line);
		@(posedge ref_clk);
		trig[line] <= 1'b1;
		repeat (40) @(posedge ref_clk);
		trig[line] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
/*
 bench for the sample sync block against one peer model.
 assumes the peer owns the timebase unless told to release it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mdss_map.svh"
module testbench
	import mdss_pkg::*;
;
	logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
	logic star_out, star_oe, conv_reset, conv_ready, acq_run, sample_strobe, timebase;
	logic [9:0] bus_out, bus_oe, peer_out, peer_oe, bus_in;
	int error_cnt = 0, compares = 0, n;
	always #5 ref_clk = ~ref_clk;
	assign bus_in = (bus_oe & bus_out) | (~bus_oe & peer_oe & peer_out);
	mdss_peer i_peer (.ref_clk(ref_clk), .timebase(timebase), .peer_out(peer_out),
		.peer_oe(peer_oe));
	mdss_sample_sync i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.local_timebase(timebase), .star_in(timebase), .star_out(star_out),
		.star_oe(star_oe), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
		.conv_reset(conv_reset), .conv_ready(conv_ready), .acq_run(acq_run),
		.sample_strobe(sample_strobe));
	task tally_and_finish;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task rdchk(input string nm, input logic [3:0] a, input logic [15:0] e);
		rd(a);
		chk(nm, e, d);
	endtask
	// polling is bounded; a miss ends the run
	task wait_st(input logic [2:0] s);
		rd(`MDSS_ADDR_STATUS);
		for (int i = 0; i < 500 && d[2:0] !== s; i++) rd(`MDSS_ADDR_STATUS);
		chk("status", {13'h0000, s}, {13'h0000, d[2:0]});
		if (d[2:0] !== s) tally_and_finish;
	endtask
	// 96 cycles hold exactly six timebase periods, whatever the phase
	task count_hi(input int sel);
		n = 0;
		repeat (96) begin
			@(posedge ref_clk);
			#1 n += (sel == 9) ? bus_oe[9] : ((sel == 1) ? star_out : sample_strobe);
		end
	endtask
	task t_reset;
		rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("conv_reset", 16'h0001, {15'h0000, conv_reset});
		chk("bus_oe", 16'h0000, {6'h00, bus_oe});
		rst <= 1'b0;
		d = 16'h0000;
		rdchk("route", `MDSS_ADDR_ROUTE, 16'h0098);
		rdchk("delay", `MDSS_ADDR_DELAY, 16'h0010);
		rdchk("rate", `MDSS_ADDR_RATE, 16'h0000);
		rdchk("settle", `MDSS_ADDR_SETTLE, 16'h0100);
		rdchk("unmapped", 4'hf, 16'h0000);
		wr(`MDSS_ADDR_ROUTE, 16'h0f98);
		rdchk("route", `MDSS_ADDR_ROUTE, 16'h0698);
		wr(`MDSS_ADDR_SETTLE, 16'h0004);
		$display("test reset done");
	endtask
	task t_slave;
		wr(`MDSS_ADDR_CTRL, 16'h0020);
		i_peer.pulse(9);
		wait_st(MDSS_SETTLE);
		chk("conv_reset", 16'h0001, {15'h0000, conv_reset});
		chk("conv_ready", 16'h0000, {15'h0000, conv_ready});
		wait_st(MDSS_ARMED);
		chk("conv_ready", 16'h0001, {15'h0000, conv_ready});
		i_peer.pulse(6);
		wait_st(MDSS_RUN);
		chk("acq_run", 16'h0001, {15'h0000, acq_run});
		count_hi(0);
		chk("strobes", 16'h0006, n[15:0]);
		$display("test slave done");
	endtask
	task t_master;
		t_reset;
		i_peer.release_tb;
		wr(`MDSS_ADDR_CTRL, 16'h0003);
		repeat (3) @(posedge ref_clk);
		chk("star_oe", 16'h0001, {15'h0000, star_oe});
		count_hi(1);
		chk("star_out high", 16'd48, n[15:0]);
		wr(`MDSS_ADDR_CTRL, 16'h0007);
		repeat (3) @(posedge ref_clk);
		chk("star_oe", 16'h0000, {15'h0000, star_oe});
		wr(`MDSS_ADDR_CTRL, 16'h0049);
		count_hi(9);
		chk("sync width", 16'd42, n[15:0]);
		chk("tb line", 16'h0001, {15'h0000, bus_oe[8]});
		wait_st(MDSS_ARMED);
		rdchk("latency", `MDSS_ADDR_LATENCY, 16'h0004);
		wr(`MDSS_ADDR_DELAY, d);
		wr(`MDSS_ADDR_CTRL, 16'h0071);
		wait_st(MDSS_WAIT);
		wait_st(MDSS_RUN);
		chk("start lines", 16'h0040, {9'h000, bus_oe[6:0]});
		$display("test master done");
	endtask
	task t_alias;
		wr(`MDSS_ADDR_RATE, 16'h0001);
		wr(`MDSS_ADDR_CTRL, 16'h00a1);
		count_hi(0);
		chk("alias strobes", 16'h0003, n[15:0]);
		$display("test alias done");
	endtask
	initial begin
		t_reset;
		t_slave;
		t_master;
		t_alias;
		tally_and_finish;
	end
endmodule
`default_nettype wire
